// [rtl/lppc_top.sv]
// low-power pin control: APB registers and registered sleep outputs
`timescale 1ns/1ps
module lppc_top
   import lppc_pkg::*;
(
   input  wire logic               clk_in,
   input  wire logic               reset_n_in,
   input  wire logic               ce_in,
   input  wire logic               psel_in,
   input  wire logic               penable_in,
   input  wire logic               pwrite_in,
   input  wire logic [LPPC_AW-1:0] paddr_in,
   input  wire logic [LPPC_DW-1:0] pwdata_in,
   output logic      [LPPC_DW-1:0] prdata_out,
   output logic                    pready_out,
   output logic                    pslverr_out,
   input  wire logic               powerdown_pin_in,
   output logic                    serializer_phy_sleep_out,
   output logic                    link_tx_sleep_out,
   output logic                    datapath_sleep_out,
   output logic                    reference_sleep_out,
   output logic                    clock_top_sleep_out,
   output logic                    converters_sleep_out,
   output logic                    bandgap_on_out
);

   typedef struct packed {
      logic [5:0]         src;
      logic [1:0]         pin_active_level;
      logic [5:0]         cfg;
      logic [5:0]         mask;
      logic [5:0]         sleep;
      logic               bandgap;
      logic [LPPC_DW-1:0] prdata;
      logic               pslverr;
      logic               loaded;
   } lppc_state_t;

   localparam lppc_state_t LPPC_STATE_RST = '{
      src:     LPPC_RST_SRC_SEL,
      pin_active_level:     LPPC_RST_POL,
      cfg:     LPPC_RST_CFG,
      mask:    LPPC_RST_MASK,
      sleep:   6'h00,
      bandgap: 1'b0,
      prdata:  32'h0000_0000,
      pslverr: 1'b0,
      loaded:  1'b0
   };

   lppc_state_t r_reg;
   lppc_state_t r_next;
   logic [1:0]  rst_sync_reg;
   logic        rst_n;
   lppc_sel_t   sel;
   logic        wr_access;
   logic        pin_act;

   lppc_ctrl_if ctl ();

   ////////////////////////////////////////////////////////////////////////
   // reset release

   always_ff @(posedge clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_sync_reg <= 2'b00;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_reg[1];

   ////////////////////////////////////////////////////////////////////////
   // address decode

   // a full word address match is required; anything else is an error
   function automatic lppc_sel_t lppc_decode(input logic [LPPC_AW-1:0] a);
      if (a == LPPC_ADDR_SRC_SEL) begin
         return LPPC_SEL_SRC;
      end else if (a == LPPC_ADDR_POL) begin
         return LPPC_SEL_POL;
      end else if (a == LPPC_ADDR_CFG) begin
         return LPPC_SEL_CFG;
      end else if (a == LPPC_ADDR_MASK) begin
         return LPPC_SEL_MASK;
      end else begin
         return LPPC_SEL_NONE;
      end
   endfunction

   assign sel        = lppc_decode(paddr_in);
   // a frozen block must not complete a transfer it cannot record, and
   // read data must be latched before the transfer may complete
   assign pready_out = psel_in && penable_in && ce_in && r_reg.loaded;
   assign wr_access  = pready_out && pwrite_in;

   ////////////////////////////////////////////////////////////////////////
   // gating

   assign ctl.src_sel   = r_reg.src;
   assign ctl.pin_pol   = r_reg.pin_active_level;
   assign ctl.cfg       = r_reg.cfg;
   assign ctl.pin_gate  = r_reg.mask;
   assign ctl.pin_level = powerdown_pin_in;

   lppc_gate u_gate (
      .ctl (ctl.gate)
   );

   assign pin_act = lppc_pin_asserted(powerdown_pin_in, r_reg.pin_active_level);

   ////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      r_next = r_reg;
      if (ce_in) begin
         if (psel_in && !r_reg.loaded) begin
            // latched once per transfer, also when the setup edge was
            // frozen; costs one wait state only in that case
            r_next.loaded  = 1'b1;
            r_next.pslverr = (sel == LPPC_SEL_NONE);
            case (sel)
               LPPC_SEL_SRC:  r_next.prdata = {26'h0, r_reg.src};
               LPPC_SEL_POL:  r_next.prdata = {30'h0, r_reg.pin_active_level};
               LPPC_SEL_CFG:  r_next.prdata = {26'h0, r_reg.cfg};
               LPPC_SEL_MASK: r_next.prdata = {26'h0, r_reg.mask};
               default:       r_next.prdata = 32'h0000_0000;
            endcase
         end
         if (wr_access) begin
            case (sel)
               LPPC_SEL_SRC:  r_next.src  = pwdata_in[5:0];
               LPPC_SEL_POL:  r_next.pin_active_level  = pwdata_in[1:0];
               LPPC_SEL_CFG:  r_next.cfg  = pwdata_in[5:0];
               LPPC_SEL_MASK: r_next.mask = pwdata_in[5:0];
               default:       r_next.cfg  = r_reg.cfg;
            endcase
         end
         if (pready_out) begin
            r_next.loaded = 1'b0;
         end
         r_next.sleep   = ctl.sleep_req;
         r_next.bandgap = 1'b1;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n) begin
      if (!rst_n) begin
         r_reg <= LPPC_STATE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign prdata_out               = r_reg.prdata;
   assign pslverr_out              = r_reg.pslverr;
   assign serializer_phy_sleep_out = r_reg.sleep[LPPC_BIT_PHY];
   assign link_tx_sleep_out        = r_reg.sleep[LPPC_BIT_LINK];
   assign datapath_sleep_out       = r_reg.sleep[LPPC_BIT_DP];
   assign reference_sleep_out      = r_reg.sleep[LPPC_BIT_REF];
   assign clock_top_sleep_out      = r_reg.sleep[LPPC_BIT_CLK];
   assign converters_sleep_out     = r_reg.sleep[LPPC_BIT_ADC];
   assign bandgap_on_out           = r_reg.bandgap;

   ////////////////////////////////////////////////////////////////////////
   // checks

   property p_ref_pin;
      @(posedge clk_in) disable iff (!rst_n)
      ce_in && r_reg.src[LPPC_BIT_REF] |=>
         reference_sleep_out == $past(pin_act && r_reg.mask[LPPC_BIT_REF]);
   endproperty
   a_ref_pin: assert property (p_ref_pin)
      else $error("reference sleep does not follow gated pin");

   property p_adc_cfg_only;
      @(posedge clk_in) disable iff (!rst_n)
      ce_in && !r_reg.src[LPPC_BIT_ADC] |=>
         converters_sleep_out == $past(r_reg.cfg[LPPC_BIT_ADC]);
   endproperty
   a_adc_cfg_only: assert property (p_adc_cfg_only)
      else $error("converters sleep not taken from config bit");

   property p_phy_masked;
      @(posedge clk_in) disable iff (!rst_n)
      ce_in && r_reg.src[LPPC_BIT_PHY] && !r_reg.mask[LPPC_BIT_PHY] |=>
         !serializer_phy_sleep_out;
   endproperty
   a_phy_masked: assert property (p_phy_masked)
      else $error("masked pin reached the serializer phy");

   property p_pol_low;
      @(posedge clk_in) disable iff (!rst_n)
      ce_in && r_reg.pin_active_level == LPPC_POL_ACTIVE_LOW && r_reg.src[LPPC_BIT_CLK]
         && r_reg.mask[LPPC_BIT_CLK] |=>
         clock_top_sleep_out == !$past(powerdown_pin_in);
   endproperty
   a_pol_low: assert property (p_pol_low)
      else $error("active low pin not honoured for clock top");

   property p_phy_cfg;
      @(posedge clk_in) disable iff (!rst_n)
      ce_in && !r_reg.src[LPPC_BIT_PHY] |=>
         serializer_phy_sleep_out == $past(r_reg.cfg[LPPC_BIT_PHY]);
   endproperty
   a_phy_cfg: assert property (p_phy_cfg)
      else $error("serializer phy sleep differs from config bit");

   property p_link_cfg;
      @(posedge clk_in) disable iff (!rst_n)
      ce_in && !r_reg.src[LPPC_BIT_LINK] && r_reg.cfg[LPPC_BIT_LINK] |=>
         link_tx_sleep_out;
   endproperty
   a_link_cfg: assert property (p_link_cfg)
      else $error("link transmitter not asleep under config bit");

   property p_dp_cfg;
      @(posedge clk_in) disable iff (!rst_n)
      ce_in && !r_reg.src[LPPC_BIT_DP] && !r_reg.cfg[LPPC_BIT_DP] |=>
         !datapath_sleep_out;
   endproperty
   a_dp_cfg: assert property (p_dp_cfg)
      else $error("datapath asleep with config bit clear");

   property p_bandgap;
      @(posedge clk_in) disable iff (!rst_n)
      ce_in |=> bandgap_on_out;
   endproperty
   a_bandgap: assert property (p_bandgap)
      else $error("bandgap dropped");

   property p_clk_cfg;
      @(posedge clk_in) disable iff (!rst_n)
      ce_in && !r_reg.src[LPPC_BIT_CLK] |=>
         clock_top_sleep_out == $past(r_reg.cfg[LPPC_BIT_CLK]);
   endproperty
   a_clk_cfg: assert property (p_clk_cfg)
      else $error("clock top sleep differs from config bit");

   property p_dp_pin;
      @(posedge clk_in) disable iff (!rst_n)
      ce_in && r_reg.src[LPPC_BIT_DP] && r_reg.mask[LPPC_BIT_DP]
         && pin_act |=> datapath_sleep_out;
   endproperty
   a_dp_pin: assert property (p_dp_pin)
      else $error("unmasked pin did not reach the datapath");

   property p_link_release;
      @(posedge clk_in) disable iff (!rst_n)
      (ce_in && r_reg.src[LPPC_BIT_LINK] && r_reg.mask[LPPC_BIT_LINK]
         && pin_act) ##1
      (ce_in && r_reg.src[LPPC_BIT_LINK] && r_reg.mask[LPPC_BIT_LINK]
         && !pin_act) |=> !link_tx_sleep_out && $past(link_tx_sleep_out);
   endproperty
   a_link_release: assert property (p_link_release)
      else $error("link transmitter did not follow pin release");

   property p_freeze;
      @(posedge clk_in) disable iff (!rst_n)
      !ce_in |=> $stable(r_reg);
   endproperty
   a_freeze: assert property (p_freeze)
      else $error("state changed while clock enable low");

   property p_adc_pin;
      @(posedge clk_in) disable iff (!rst_n)
      ce_in && r_reg.src[LPPC_BIT_ADC] |=>
         converters_sleep_out == $past(pin_act && r_reg.mask[LPPC_BIT_ADC]);
   endproperty
   a_adc_pin: assert property (p_adc_pin)
      else $error("converters sleep does not follow gated pin");

   property p_clk_masked;
      @(posedge clk_in) disable iff (!rst_n)
      ce_in && r_reg.src[LPPC_BIT_CLK] && !r_reg.mask[LPPC_BIT_CLK] |=>
         !clock_top_sleep_out;
   endproperty
   a_clk_masked: assert property (p_clk_masked)
      else $error("masked pin reached the clock top");

   property p_ref_cfg;
      @(posedge clk_in) disable iff (!rst_n)
      ce_in && !r_reg.src[LPPC_BIT_REF] |=>
         reference_sleep_out == $past(r_reg.cfg[LPPC_BIT_REF]);
   endproperty
   a_ref_cfg: assert property (p_ref_cfg)
      else $error("reference sleep differs from config bit");

endmodule // lppc_top

// [rtl/lppc_pkg.sv]
// constants, types and helpers for the low-power pin control block
package lppc_pkg;

   localparam int          LPPC_AW      = 10;
   localparam int          LPPC_DW      = 32;
   localparam int          LPPC_NUM_SUB = 6;

   // register indices; byte address is four times the index
   localparam logic [7:0]  LPPC_IDX_SRC_SEL = 8'h30;
   localparam logic [7:0]  LPPC_IDX_POL     = 8'h31;
   localparam logic [7:0]  LPPC_IDX_CFG     = 8'h32;
   localparam logic [7:0]  LPPC_IDX_MASK    = 8'h33;

   localparam logic [9:0]  LPPC_ADDR_SRC_SEL = {LPPC_IDX_SRC_SEL, 2'b00};
   localparam logic [9:0]  LPPC_ADDR_POL     = {LPPC_IDX_POL, 2'b00};
   localparam logic [9:0]  LPPC_ADDR_CFG     = {LPPC_IDX_CFG, 2'b00};
   localparam logic [9:0]  LPPC_ADDR_MASK    = {LPPC_IDX_MASK, 2'b00};

   // sub-block bit positions, shared by select, config and mask
   localparam int          LPPC_BIT_PHY  = 5;
   localparam int          LPPC_BIT_LINK = 4;
   localparam int          LPPC_BIT_DP   = 3;
   localparam int          LPPC_BIT_REF  = 2;
   localparam int          LPPC_BIT_CLK  = 1;
   localparam int          LPPC_BIT_ADC  = 0;

   localparam logic [1:0]  LPPC_POL_ACTIVE_HIGH = 2'h0;
   localparam logic [1:0]  LPPC_POL_ACTIVE_LOW  = 2'h1;

   localparam logic [5:0]  LPPC_RST_SRC_SEL = 6'h00;
   localparam logic [1:0]  LPPC_RST_POL     = 2'h0;
   localparam logic [5:0]  LPPC_RST_CFG     = 6'h00;
   localparam logic [5:0]  LPPC_RST_MASK    = 6'h00;

   typedef enum logic [2:0] {
      LPPC_SEL_NONE,
      LPPC_SEL_SRC,
      LPPC_SEL_POL,
      LPPC_SEL_CFG,
      LPPC_SEL_MASK
   } lppc_sel_t;

   // codes 2 and 3 are undefined; they fall back to active high
   function automatic logic lppc_pin_asserted(input logic       level,
                                              input logic [1:0] pin_active_level);
      if (pin_active_level == LPPC_POL_ACTIVE_LOW)
         return !level;
      else
         return level;
   endfunction

endpackage

// [rtl/lppc_ctrl_if.sv]
// control bundle between the register file and the sleep gating
`timescale 1ns/1ps
interface lppc_ctrl_if;
   logic [5:0] src_sel;
   logic [1:0] pin_pol;
   logic [5:0] cfg;
   logic [5:0] pin_gate;
   logic       pin_level;
   logic [5:0] sleep_req;

   modport ctrl (output src_sel, output pin_pol, output cfg,
                 output pin_gate, output pin_level, input sleep_req);
   modport gate (input src_sel, input pin_pol, input cfg,
                 input pin_gate, input pin_level, output sleep_req);
endinterface

// [rtl/lppc_gate.sv]
// per sub-block choice between pin control and configuration bit
`timescale 1ns/1ps
module lppc_gate
   import lppc_pkg::*;
(
   lppc_ctrl_if.gate ctl
);

   logic pin_act;

   assign pin_act = lppc_pin_asserted(ctl.pin_level, ctl.pin_pol);

   genvar i;
   generate
      for (i = 0; i < LPPC_NUM_SUB; i++) begin : g_sub
         // pin path is gated by its mask; config path ignores the pin
         assign ctl.sleep_req[i] = ctl.src_sel[i] ?
                                   (pin_act & ctl.pin_gate[i]) :
                                   ctl.cfg[i];
      end
   endgenerate

endmodule // lppc_gate

// [verification/lppc_pin_drv.sv]
// system-side model that drives the power-down pin
`timescale 1ns/1ps
module lppc_pin_drv (
   input  wire logic clk_in,
   input  wire logic req_in,
   input  wire logic active_low_in,
   output logic      pin_out
);
   logic pin_reg = 1'b0;

   // active level when low power is wanted, inactive otherwise
   always @(posedge clk_in) begin
      pin_reg <= req_in ^ active_low_in;
   end

   assign pin_out = pin_reg;
endmodule // lppc_pin_drv

// [verification/tb_low_power_pin_control.sv]
// self-checking bench for the low-power pin control block
`timescale 1ns/1ps
module tb_low_power_pin_control
   import lppc_pkg::*;
;

   logic        clk_in = 1'b0;
   logic        reset_n_in = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [9:0]  paddr = 10'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        pin;
   logic        req = 1'b0;
   logic        ce = 1'b1;
   logic        bandgap;
   logic [5:0]  slp;
   logic [5:0]  exp6;
   logic [31:0] rd;
   logic        er;
   logic [31:0] regs [4];
   logic [15:0] lfsr = 16'h0043;
   int          fails = 0;
   int          check_count = 0;
   int          cyc = 0;
   logic [9:0]  adr [4] = '{LPPC_ADDR_SRC_SEL, LPPC_ADDR_POL,
                            LPPC_ADDR_CFG, LPPC_ADDR_MASK};
   logic [31:0] wm [4] = '{32'h3F, 32'h3, 32'h3F, 32'h3F};

   initial begin
      forever #50 clk_in = ~clk_in;
   end

   lppc_top u_lppc_top (
      .clk_in(clk_in), .reset_n_in(reset_n_in), .ce_in(ce),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
      .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(pslverr),
      .powerdown_pin_in(pin),
      .serializer_phy_sleep_out(slp[5]), .link_tx_sleep_out(slp[4]),
      .datapath_sleep_out(slp[3]), .reference_sleep_out(slp[2]),
      .clock_top_sleep_out(slp[1]), .converters_sleep_out(slp[0]),
      .bandgap_on_out(bandgap)
   );

   lppc_pin_drv u_lppc_pin_drv (
      .clk_in(clk_in), .req_in(req),
      .active_low_in(regs[1][1:0] == 2'h1), .pin_out(pin)
   );

   function automatic logic [15:0] next_rand(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   function automatic logic [5:0] exp_sleep(input logic [5:0] s,
                                            input logic [5:0] c,
                                            input logic [5:0] m,
                                            input logic       rq);
      // the model drives the pin active exactly while rq is high
      return (s & m & {6{rq}}) | (~s & c);
   endfunction

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic summarize();
      if (fails == 0 && check_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [9:0] a,
                      input logic [31:0] d);
      @(posedge clk_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clk_in);
      penable <= 1'b1;
      // only the bench timeout ends a wait for the answer
      do begin
         @(posedge clk_in);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // writes all four registers, reads them back, then moves the pin
   task automatic scen(input logic [31:0] v0, input logic [31:0] v1,
                       input logic [31:0] v2, input logic [31:0] v3,
                       input logic rq);
      regs = '{v0, v1, v2, v3};
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, adr[i], regs[i]);
      end
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, adr[i], 32'h0);
         check("readback", rd, regs[i] & wm[i]);
      end
      req <= rq;
      exp6 = exp_sleep(v0[5:0], v2[5:0], v3[5:0], rq);
      repeat (3) @(posedge clk_in);
      @(negedge clk_in);
   endtask

   always @(posedge clk_in) begin
      cyc++;
      // one frozen cycle in seven stalls transfers at every phase
      ce <= (cyc % 7) != 0;
      if (cyc == 8000) begin
         fails++;
         summarize();
      end
   end

   initial begin
      regs = '{32'h0, 32'h0, 32'h0, 32'h0};
      repeat (4) @(posedge clk_in);
      reset_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      for (int i = 0; i < 4; i++) begin
         apb(1'b0, adr[i], 32'h0);
         check("reset value", rd, 32'h0);
      end
      check("sleep after reset", 32'(slp), 32'h0);
      apb(1'b1, 10'h0D0, 32'hFFFF_FFFF);
      check("unmapped write err", 32'(er), 32'h1);
      apb(1'b0, 10'h0D0, 32'h0);
      check("unmapped read", rd, 32'h0);
      check("unmapped read err", 32'(er), 32'h1);
      for (int b = 0; b < 6; b++) begin
         scen(32'h0, 32'h0, 32'h1 << b, 32'h0, 1'b1);
         check("cfg sleep", 32'(slp), 32'(exp6));
      end
      check("bandgap", 32'(bandgap), 32'h1);
      for (int b = 0; b < 6; b++) begin
         scen(32'h3F, 32'h0, 32'h0, 32'h1 << b, 1'b1);
         check("mask sleep", 32'(slp), 32'(exp6));
      end
      scen(32'h3F, 32'h1, 32'h0, 32'h3F, 1'b1);
      check("low pin sleep", 32'(slp), 32'h3F);
      scen(32'h3F, 32'h1, 32'h3F, 32'h3F, 1'b0);
      check("low pin awake", 32'(slp), 32'h0);
      for (int k = 0; k < 40; k++) begin
         lfsr = next_rand(lfsr);
         regs[0] = {16'h0, lfsr};
         lfsr = next_rand(lfsr);
         regs[1] = {lfsr, 16'h0};
         lfsr = next_rand(lfsr);
         scen(regs[0], {30'h0, lfsr[1:0]}, {16'h0, lfsr},
              {regs[1][31:16], lfsr}, lfsr[9] ^ lfsr[3]);
         check("random sleep", 32'(slp), 32'(exp6));
      end
      // second reset in mid-run returns everything to config control
      @(posedge clk_in);
      reset_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      reset_n_in <= 1'b1;
      repeat (3) @(posedge clk_in);
      apb(1'b0, adr[2], 32'h0);
      check("config after mid reset", rd, 32'h0);
      check("sleep after mid reset", 32'(slp), 32'h0);
      summarize();
   end
endmodule // tb_low_power_pin_control
